// ---- hw/serial_port_map.svh ----
// register map, field positions, reset values and frame lengths of the serial port
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH
// ==========================================================
// register offsets on the special-function bus
`define SLAVE_ADDRESS_MASK_OFS 8'hAE
`define SERIAL_CONTROL_OFS 8'hF1
`define SERIAL_DATA_BUFFER_OFS 8'hF2
`define SLAVE_ADDRESS_OFS 8'hF3
`define REG_RESET_VALUE 8'h00
// ==========================================================
// serial_control field positions
`define RECEIVE_DONE_BIT 0
`define TRANSMIT_DONE_BIT 1
`define RX_NINTH_BIT 2
`define TX_NINTH_BIT 3
`define RECEIVE_ENABLE_BIT 4
`define MULTIPROC_BIT 5
`define MODE_LO_BIT 6
`define MODE_HI_BIT 7
// ==========================================================
// frame lengths in bit times, and an idle shift pattern
`define FRAME_LEN_SYNC 4'h8
`define FRAME_LEN_ASYNC8 4'hA
`define FRAME_LEN_ASYNC9 4'hB
`define FRAME_LEN_MAX 4'hB
`define FRAME_IDLE 11'h7FF
`endif

// ---- hw/serial_port_pkg.sv ----
// types shared by the serial port control logic and its frame engine
`default_nettype none
package serial_port_pkg;
   // operating mode as {mode_select_hi, mode_select_lo}
   typedef enum logic [1:0] {
      MODE_SYNC = 2'h0,
      MODE_ASYNC8 = 2'h1,
      MODE_ASYNC9_FIXED = 2'h2,
      MODE_ASYNC9_VAR = 2'h3
   } mode_type;
   typedef enum logic {SHIFT_IDLE = 1'b0, SHIFT_RUN = 1'b1} shift_state_type;
   // one received frame, valid for a single cycle
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic ninth;
      logic stop;
   } rx_event_type;
   // transmit request from the data buffer write
   typedef struct packed {
      logic start;
      logic [7:0] data;
      logic ninth;
   } tx_req_type;
endpackage
`default_nettype wire

// ---- hw/serial_frame_engine.sv ----
// bit-level shifter: sends and receives one frame per request, one bit per baud tick
`include "serial_port_map.svh"
`default_nettype none
module serial_frame_engine (
   input wire logic i_mclk, // system clock
   input wire logic i_arst_n, // async reset, active low
   input wire logic i_baud_tick, // one pulse per bit time (mid-bit for receive)
   input wire serial_port_pkg::mode_type i_mode, // operating mode
   input wire logic i_rx_enable, // receiver enabled
   input wire serial_port_pkg::tx_req_type i_tx, // transmit request
   input wire logic i_rxd, // receive pin, asynchronous
   output logic o_txd, // transmit pin
   output logic o_tx_busy, // frame in flight
   output logic o_tx_done, // one-cycle pulse: byte sent
   output serial_port_pkg::rx_event_type o_rx // received frame
);
   serial_port_pkg::shift_state_type tx_state_q, rx_state_q;
   logic [10:0] tx_sh_q, rx_sh_q, rx_full, rx_just;
   logic [3:0] tx_cnt_q, rx_cnt_q, rx_len;
   logic txd_q, tx_done_q, rxd_meta_q, rxd_sync_q;
   serial_port_pkg::rx_event_type rx_q;

   // frame length in bit times for a mode
   function automatic logic [3:0] frame_len(input serial_port_pkg::mode_type m);
      unique case (m)
         serial_port_pkg::MODE_SYNC: frame_len = `FRAME_LEN_SYNC;
         serial_port_pkg::MODE_ASYNC8: frame_len = `FRAME_LEN_ASYNC8;
         serial_port_pkg::MODE_ASYNC9_FIXED,
         serial_port_pkg::MODE_ASYNC9_VAR: frame_len = `FRAME_LEN_ASYNC9;
      endcase
   endfunction

   // ==========================================================
   // transmitter
   // async frames are loaded start-bit first; sync sends only the 8 data bits
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_state_q <= serial_port_pkg::SHIFT_IDLE;
         tx_sh_q <= `FRAME_IDLE;
         tx_cnt_q <= 4'h0;
         txd_q <= 1'b1;
         tx_done_q <= 1'b0;
      end else begin
         tx_done_q <= 1'b0;
         unique case (tx_state_q)
            serial_port_pkg::SHIFT_IDLE: begin
               if (i_tx.start) begin
                  tx_state_q <= serial_port_pkg::SHIFT_RUN;
                  tx_cnt_q <= 4'h0;
                  unique case (i_mode)
                     serial_port_pkg::MODE_SYNC: tx_sh_q <= {3'h7, i_tx.data};
                     serial_port_pkg::MODE_ASYNC8: tx_sh_q <= {2'h3, i_tx.data, 1'b0};
                     serial_port_pkg::MODE_ASYNC9_FIXED,
                     serial_port_pkg::MODE_ASYNC9_VAR:
                        tx_sh_q <= {1'b1, i_tx.ninth, i_tx.data, 1'b0};
                  endcase
               end
            end
            serial_port_pkg::SHIFT_RUN: begin
               if (i_baud_tick) begin
                  if (tx_cnt_q == frame_len(i_mode)) begin
                     // last bit time over: line back to idle
                     tx_state_q <= serial_port_pkg::SHIFT_IDLE;
                     txd_q <= 1'b1;
                     tx_done_q <= (i_mode == serial_port_pkg::MODE_SYNC);
                  end else begin
                     txd_q <= tx_sh_q[0];
                     tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                     tx_cnt_q <= tx_cnt_q + 4'h1;
                     // stop bit just launched in the async modes
                     tx_done_q <= (i_mode != serial_port_pkg::MODE_SYNC) &&
                                  (tx_cnt_q + 4'h1 == frame_len(i_mode));
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // receiver
   // two flops before anything looks at the pin
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rxd_meta_q <= 1'b1;
         rxd_sync_q <= 1'b1;
      end else begin
         rxd_meta_q <= i_rxd;
         rxd_sync_q <= rxd_meta_q;
      end
   end

   // right-justify the captured samples so bit 0 is the first sample
   always_comb begin
      rx_len = frame_len(i_mode);
      rx_full = {rxd_sync_q, rx_sh_q[10:1]};
      rx_just = rx_full >> (`FRAME_LEN_MAX - rx_len);
   end

   // dropping the receive enable aborts a frame in progress
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_state_q <= serial_port_pkg::SHIFT_IDLE;
         rx_sh_q <= `FRAME_IDLE;
         rx_cnt_q <= 4'h0;
         rx_q <= '0;
      end else begin
         rx_q.valid <= 1'b0;
         unique case (rx_state_q)
            serial_port_pkg::SHIFT_IDLE: begin
               if (i_rx_enable &&
                   (i_mode == serial_port_pkg::MODE_SYNC || !rxd_sync_q)) begin
                  rx_state_q <= serial_port_pkg::SHIFT_RUN;
                  rx_cnt_q <= 4'h0;
               end
            end
            serial_port_pkg::SHIFT_RUN: begin
               if (!i_rx_enable) begin
                  rx_state_q <= serial_port_pkg::SHIFT_IDLE;
               end else if (i_baud_tick) begin
                  rx_sh_q <= rx_full;
                  rx_cnt_q <= rx_cnt_q + 4'h1;
                  if (rx_cnt_q + 4'h1 == rx_len) begin
                     rx_state_q <= serial_port_pkg::SHIFT_IDLE;
                     rx_q.valid <= 1'b1;
                     if (i_mode == serial_port_pkg::MODE_SYNC) begin
                        rx_q.data <= rx_just[7:0];
                        rx_q.ninth <= 1'b0;
                        rx_q.stop <= 1'b1;
                     end else begin
                        rx_q.data <= rx_just[8:1];
                        rx_q.ninth <= rx_just[9];
                        rx_q.stop <= rxd_sync_q;
                     end
                  end
               end
            end
         endcase
      end
   end

   assign o_txd = txd_q;
   assign o_tx_done = tx_done_q;
   assign o_tx_busy = (tx_state_q == serial_port_pkg::SHIFT_RUN);
   assign o_rx = rx_q;
endmodule
`default_nettype wire

// ---- hw/serial_port_control.sv ----
// control, data buffer and address match of the second serial port
`include "serial_port_map.svh"
`default_nettype none
module serial_port_control (
   input wire logic i_mclk, // system clock, 125 MHz
   input wire logic i_arst_n, // async reset, active low
   input wire logic [7:0] i_sfr_addr, // register address
   input wire logic i_sfr_wr, // write strobe, one cycle
   input wire logic i_sfr_rd, // read strobe, one cycle
   input wire logic [7:0] i_sfr_wdata, // write data
   output logic [7:0] o_sfr_rdata, // read data, valid the cycle after i_sfr_rd
   input wire logic i_status_view_select, // status view bit of power_control_reg
   input wire logic i_baud_tick, // bit-time pulse from the baud generator
   input wire logic i_rxd, // receive pin
   output logic o_txd, // transmit pin
   output logic o_irq // port interrupt request, level
);
   logic [1:0] mode_q;
   logic multiproc_enable_q, receive_enable_q, tx_ninth_bit_q, rx_ninth_bit_q;
   logic transmit_done_flag_q, receive_done_flag_q;
   logic frame_error_flag_q, receive_overrun_flag_q, transmit_collision_flag_q;
   logic unread_q;
   logic [7:0] rx_latch_q, slave_address_q, slave_address_mask_q, rdata_q;
   logic wr_ctrl, wr_data, rd_data, accept, tx_busy, tx_done;
   logic is_async, is_9bit;
   serial_port_pkg::mode_type mode;
   serial_port_pkg::rx_event_type rx_evt;
   serial_port_pkg::tx_req_type tx_req;

   // masked compare of one address byte against a pattern
   function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] m);
      masked_eq = ((a ^ b) & m) == 8'h00;
   endfunction

   // ==========================================================
   // register decode
   assign wr_ctrl = i_sfr_wr && (i_sfr_addr == `SERIAL_CONTROL_OFS);
   assign wr_data = i_sfr_wr && (i_sfr_addr == `SERIAL_DATA_BUFFER_OFS);
   assign rd_data = i_sfr_rd && (i_sfr_addr == `SERIAL_DATA_BUFFER_OFS);
   assign mode = serial_port_pkg::mode_type'(mode_q);
   assign is_async = (mode != serial_port_pkg::MODE_SYNC);
   assign is_9bit = mode_q[1];

   // ==========================================================
   // receive qualification
   // an address byte passes on the own address or on the broadcast pattern
   always_comb begin
      logic hit;
      hit = masked_eq(rx_evt.data, slave_address_q, slave_address_mask_q) ||
            masked_eq(rx_evt.data, slave_address_q | slave_address_mask_q,
                      slave_address_q | slave_address_mask_q);
      unique case (mode)
         serial_port_pkg::MODE_SYNC: accept = rx_evt.valid;
         serial_port_pkg::MODE_ASYNC8:
            accept = rx_evt.valid && (!multiproc_enable_q || rx_evt.stop);
         serial_port_pkg::MODE_ASYNC9_FIXED,
         serial_port_pkg::MODE_ASYNC9_VAR:
            accept = rx_evt.valid && (!multiproc_enable_q || (rx_evt.ninth && hit));
      endcase
   end

   // ==========================================================
   // mode and configuration bits
   // mode bits are only writable while the status view is off
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_q <= 2'h0;
         multiproc_enable_q <= 1'b0;
         receive_enable_q <= 1'b0;
         tx_ninth_bit_q <= 1'b0;
         slave_address_q <= `REG_RESET_VALUE;
         slave_address_mask_q <= `REG_RESET_VALUE;
      end else begin
         if (wr_ctrl && !i_status_view_select) begin
            mode_q <= {i_sfr_wdata[`MODE_HI_BIT], i_sfr_wdata[`MODE_LO_BIT]};
            multiproc_enable_q <= i_sfr_wdata[`MULTIPROC_BIT];
         end
         if (wr_ctrl) begin
            receive_enable_q <= i_sfr_wdata[`RECEIVE_ENABLE_BIT];
            tx_ninth_bit_q <= i_sfr_wdata[`TX_NINTH_BIT];
         end
         if (i_sfr_wr && i_sfr_addr == `SLAVE_ADDRESS_OFS) begin
            slave_address_q <= i_sfr_wdata;
         end
         if (i_sfr_wr && i_sfr_addr == `SLAVE_ADDRESS_MASK_OFS) begin
            slave_address_mask_q <= i_sfr_wdata;
         end
      end
   end

   // ==========================================================
   // transmit and receive flags
   // hardware only sets; a set in the same cycle as a software write wins
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         transmit_done_flag_q <= 1'b0;
         receive_done_flag_q <= 1'b0;
      end else begin
         if (tx_done) begin
            transmit_done_flag_q <= 1'b1;
         end else if (wr_ctrl) begin
            transmit_done_flag_q <= i_sfr_wdata[`TRANSMIT_DONE_BIT];
         end
         if (accept) begin
            receive_done_flag_q <= 1'b1;
         end else if (wr_ctrl) begin
            receive_done_flag_q <= i_sfr_wdata[`RECEIVE_DONE_BIT];
         end
      end
   end

   // ==========================================================
   // receive latch and ninth bit
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_latch_q <= `REG_RESET_VALUE;
         rx_ninth_bit_q <= 1'b0;
         unread_q <= 1'b0;
      end else begin
         if (accept) begin
            rx_latch_q <= rx_evt.data;
         end
         if (accept && is_9bit) begin
            rx_ninth_bit_q <= rx_evt.ninth;
         end else if (accept && mode == serial_port_pkg::MODE_ASYNC8 && !multiproc_enable_q) begin
            rx_ninth_bit_q <= rx_evt.stop;
         end else if (wr_ctrl) begin
            rx_ninth_bit_q <= i_sfr_wdata[`RX_NINTH_BIT];
         end
         // a byte arriving with the read still counts as unread
         if (accept) begin
            unread_q <= 1'b1;
         end else if (rd_data) begin
            unread_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // status bits: sticky, cleared by writing 0 through the status view
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         frame_error_flag_q <= 1'b0;
         receive_overrun_flag_q <= 1'b0;
         transmit_collision_flag_q <= 1'b0;
      end else begin
         if (rx_evt.valid && is_async && !rx_evt.stop) begin
            frame_error_flag_q <= 1'b1;
         end else if (wr_ctrl && i_status_view_select) begin
            frame_error_flag_q <= i_sfr_wdata[`MODE_HI_BIT];
         end
         if (accept && is_async && unread_q) begin
            receive_overrun_flag_q <= 1'b1;
         end else if (wr_ctrl && i_status_view_select) begin
            receive_overrun_flag_q <= i_sfr_wdata[`MODE_LO_BIT];
         end
         if (wr_data && tx_busy) begin
            transmit_collision_flag_q <= 1'b1;
         end else if (wr_ctrl && i_status_view_select) begin
            transmit_collision_flag_q <= i_sfr_wdata[`MULTIPROC_BIT];
         end
      end
   end

   // ==========================================================
   // read port, registered; unmapped addresses read zero
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_q <= `REG_RESET_VALUE;
      end else if (i_sfr_rd) begin
         unique case (i_sfr_addr)
            `SERIAL_CONTROL_OFS: rdata_q <= {
               i_status_view_select ? {frame_error_flag_q, receive_overrun_flag_q,
                                       transmit_collision_flag_q}
                                    : {mode_q, multiproc_enable_q},
               receive_enable_q, tx_ninth_bit_q, rx_ninth_bit_q,
               transmit_done_flag_q, receive_done_flag_q};
            `SERIAL_DATA_BUFFER_OFS: rdata_q <= rx_latch_q;
            `SLAVE_ADDRESS_OFS: rdata_q <= slave_address_q;
            `SLAVE_ADDRESS_MASK_OFS: rdata_q <= slave_address_mask_q;
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   // a write while busy is flagged and dropped so the frame on the line stays intact
   assign tx_req = '{start: wr_data && !tx_busy, data: i_sfr_wdata,
                     ninth: tx_ninth_bit_q};
   assign o_sfr_rdata = rdata_q;
   assign o_irq = transmit_done_flag_q || receive_done_flag_q;

   serial_frame_engine u_engine (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_baud_tick(i_baud_tick),
      .i_mode(mode),
      .i_rx_enable(receive_enable_q),
      .i_tx(tx_req),
      .i_rxd(i_rxd),
      .o_txd(o_txd),
      .o_tx_busy(tx_busy),
      .o_tx_done(tx_done),
      .o_rx(rx_evt)
   );

   // ==========================================================
   // assertions
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   sequence s_load_idle;
      wr_data && !tx_busy;
   endsequence
   sequence s_shift_started;
      tx_busy && !tx_done;
   endsequence
   AST_START_TX: assert property (s_load_idle |=> s_shift_started)
      else $error("data buffer write did not start a frame");
   AST_COLLISION: assert property (wr_data && tx_busy |=> transmit_collision_flag_q)
      else $error("collision not flagged");
   AST_TX_FLAG: assert property (tx_done |=> transmit_done_flag_q && o_irq)
      else $error("transmit flag not set after frame");
   AST_NO_HW_CLEAR: assert property (receive_done_flag_q && !wr_ctrl
         |=> receive_done_flag_q)
      else $error("receive flag cleared without software");
   AST_STOP_QUAL: assert property (rx_evt.valid && mode == serial_port_pkg::MODE_ASYNC8 &&
         multiproc_enable_q && !rx_evt.stop && !receive_done_flag_q && !wr_ctrl
         |=> !receive_done_flag_q)
      else $error("low stop bit raised receive flag");
   AST_NINTH_QUAL: assert property (rx_evt.valid && is_9bit && multiproc_enable_q &&
         !rx_evt.ninth && !receive_done_flag_q && !wr_ctrl |=> !receive_done_flag_q)
      else $error("data byte raised flag in address mode");
   AST_MASK_MATCH: assert property (rx_evt.valid && is_9bit && multiproc_enable_q &&
         rx_evt.ninth && masked_eq(rx_evt.data, slave_address_q, slave_address_mask_q)
         |=> receive_done_flag_q && rx_latch_q == $past(rx_evt.data))
      else $error("matching address not accepted");
   AST_BROADCAST: assert property (rx_evt.valid && is_9bit && multiproc_enable_q &&
         rx_evt.ninth && rx_evt.data == 8'hFF |=> receive_done_flag_q)
      else $error("all-ones broadcast not accepted");
   AST_RX_DISABLED: assert property (!receive_enable_q ##1 !receive_enable_q
         |-> !rx_evt.valid)
      else $error("byte received while disabled");
   AST_NINTH_CAPTURE: assert property (accept && is_9bit
         |=> rx_ninth_bit_q == $past(rx_evt.ninth))
      else $error("ninth bit not captured");
   AST_READ_LATCH: assert property (rd_data |=> o_sfr_rdata == $past(rx_latch_q))
      else $error("data buffer read not from receive latch");
   AST_OVERRUN: assert property (accept && is_async && unread_q |=> receive_overrun_flag_q)
      else $error("overrun not flagged");
   AST_FRAME_ERR: assert property (rx_evt.valid && is_async && !rx_evt.stop
         |=> frame_error_flag_q)
      else $error("frame error not flagged");
   AST_STATUS_VIEW: assert property (i_sfr_rd && i_sfr_addr == `SERIAL_CONTROL_OFS &&
         i_status_view_select |=> o_sfr_rdata[7] == $past(frame_error_flag_q))
      else $error("status view shows wrong bit");
endmodule
`default_nettype wire

// ---- bench/serial_peer.sv ----
// remote serial peer: sends frames to the receive pin, samples the transmit pin
`default_nettype none
module serial_peer (
   input wire logic i_mclk, // system clock
   input wire logic i_baud_tick, // bit-time pulse
   input wire logic i_txd, // device transmit pin
   output logic o_rxd // device receive pin, idles high
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // line idles high; each bit changes just after a tick so the next tick samples mid-bit
   initial o_rxd = 1'b1;
   task automatic send(input logic [10:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_mclk iff i_baud_tick);
         @(negedge i_mclk) o_rxd = f[i];
      end
      @(posedge i_mclk iff i_baud_tick);
      @(negedge i_mclk) o_rxd = 1'b1;
      repeat (3) @(negedge i_mclk);
   endtask
   // a launched bit lands on the tick's own rising edge, so look two falling edges later
   task automatic grab(input int n, output logic [10:0] f);
      f = '1;
      for (int i = 0; i < n; i++) begin
         @(posedge i_mclk iff i_baud_tick);
         repeat (2) @(negedge i_mclk);
         f[i] = i_txd;
      end
   endtask
endmodule
`default_nettype wire

// ---- bench/test_serial_port_control.sv ----
// self-checking bench for the serial port control block
`default_nettype none
module test_serial_port_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk, i_arst_n, i_sfr_wr, i_sfr_rd, i_status_view_select, i_rxd;
   logic i_baud_tick = 1'b0;
   logic o_txd, o_irq, ok;
   logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, rd_val, a, m, d, latch, ctl;
   logic [7:0] rc [10];
   logic [7:0] rdat [10];
   logic [10:0] bits;
   logic [9:0] n9v, stv;
   logic [2:0] tick_cnt = 3'h0;
   logic [1:0] md;
   int fails, total_checks, seed, fe, r9, ov;
   serial_port_control dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_sfr_addr(i_sfr_addr),
      .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
      .o_sfr_rdata(o_sfr_rdata), .i_status_view_select(i_status_view_select),
      .i_baud_tick(i_baud_tick), .i_rxd(i_rxd), .o_txd(o_txd), .o_irq(o_irq));
   serial_peer peer (.i_mclk(i_mclk), .i_baud_tick(i_baud_tick), .i_txd(o_txd), .o_rxd(i_rxd));
   // ==========
   // clock and a one-cycle bit tick every eight cycles
   initial begin
      i_mclk = 1'b0;
      forever #4 i_mclk = ~i_mclk;
   end
   always @(negedge i_mclk) begin
      tick_cnt <= tick_cnt + 3'h1;
      i_baud_tick <= (tick_cnt == 3'h7);
   end
   // ==========
   // register strobes last one cycle and change only on the falling edge
   task automatic wr(input logic [7:0] ad, input logic [7:0] v);
      @(negedge i_mclk);
      i_sfr_addr = ad;
      i_sfr_wdata = v;
      i_sfr_wr = 1'b1;
      @(negedge i_mclk);
      i_sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad);
      @(negedge i_mclk);
      i_sfr_addr = ad;
      i_sfr_rd = 1'b1;
      @(negedge i_mclk);
      i_sfr_rd = 1'b0;
      rd_val = o_sfr_rdata;
   endtask
   task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic int flen(input logic [1:0] x);
      return x == 2'h0 ? 8 : x == 2'h1 ? 10 : 11;
   endfunction
   // masked own address or the broadcast address built from both registers
   function automatic logic hit(input logic [7:0] x);
      return (((x ^ a) & m) == 8'h00) || (((x ^ (a | m)) & (a | m)) == 8'h00);
   endfunction
   // ==========
   // a hang costs a mismatch, then ends the run the normal way
   initial begin
      repeat (40000) @(posedge i_mclk);
      fails++;
      $display("Error watchdog expected done seen hang");
      summarize;
   end
   initial begin
      seed = 59;
      {fails, total_checks, fe, i_arst_n, i_sfr_wr, i_sfr_rd, i_status_view_select} = '0;
      {i_sfr_addr, i_sfr_wdata, latch} = '0;
      repeat (20) @(negedge i_mclk);
      i_arst_n = 1'b1;
      // reset values, with 0x00 standing for an unmapped place
      foreach (rc[i]) rc[i] = i < 4 ? 8'hAE + 8'(i) * 8'h15 : 8'h00;
      for (int i = 0; i < 5; i++) begin
         rd(i == 4 ? 8'h00 : {1'b1, i == 0 ? 7'h2E : 7'h70 + 7'(i)});
         chk("reset", 11'h000, rd_val);
      end
      m = 8'($random(seed)) | 8'h01;
      a = 8'($random(seed)) | 8'h01;
      wr(8'hAE, m);
      wr(8'hF3, a);
      rd(8'hAE);
      chk("mask", m, rd_val);
      rd(8'hF3);
      chk("address", a, rd_val);
      $display("test registers done");
      // every mode sends one byte; a second write while busy must collide
      for (int j = 0; j < 4; j++) begin
         md = j[1:0];
         d = 8'($random(seed));
         ctl = {md, 2'b00, md[0], 3'b000};
         wr(8'hF1, ctl);
         @(posedge i_mclk iff i_baud_tick);
         wr(8'hF2, d);
         wr(8'hF2, ~d);
         peer.grab(flen(md), bits);
         repeat (2) @(posedge i_mclk iff i_baud_tick);
         chk("frame", md == 0 ? {3'b111, d} : md == 1 ? {2'b11, d, 1'b0} :
             {1'b1, md[0], d, 1'b0}, bits);
         rd(8'hF1);
         chk("control", ctl | 8'h02, rd_val);
         chk("irq", 11'(1), o_irq);
         i_status_view_select = 1'b1;
         rd(8'hF1);
         chk("status", {3'b001, ctl[4:0] | 5'h02}, rd_val);
         wr(8'hF1, 8'h00);
         i_status_view_select = 1'b0;
         rd(8'hF1);
         chk("cleared", {ctl[7:6], 6'h00}, rd_val);
         chk("irq", 11'(0), o_irq);
         $display("test transmit mode %0d done", j);
      end
      // receive cases: address filter, broadcast, stop qualification, receiver off
      d = 8'($random(seed));
      rc = '{8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hD0, 8'h70, 8'h50, 8'h50, 8'h40, 8'hB0};
      rdat = '{a ^ 8'h01, a, a, 8'hFF, d, d, ~d, d, d, a};
      n9v = 10'b1000011101;
      stv = 10'b1110011111;
      for (int i = 0; i < 10; i++) begin
         ctl = rc[i];
         md = ctl[7:6];
         r9 = 0;
         // case 7 sends its byte twice with no read between, so the second one overruns
         ov = int'(i == 7);
         wr(8'hF1, ctl);
         repeat (ov + 1) peer.send(md == 1 ? {2'b11, stv[i], rdat[i], 1'b0}
                                  : {stv[i], n9v[i], rdat[i], 1'b0}, flen(md));
         ok = ctl[4] && (md == 1 ? !(ctl[5] && !stv[i]) : (!ctl[5] || (n9v[i] && hit(rdat[i]))));
         fe = fe | int'(ctl[4] && !stv[i]);
         if (ok) begin
            latch = rdat[i];
            // 8-bit mode keeps the stop level only with the multiprocessor bit clear
            r9 = md == 1 ? int'(stv[i] && !ctl[5]) : int'(n9v[i]);
         end
         rd(8'hF1);
         chk("control", {ctl[7:3], r9[0], 1'b0, ok}, rd_val);
         chk("irq", 11'(ok), o_irq);
         rd(8'hF2);
         chk("latch", latch, rd_val);
         i_status_view_select = 1'b1;
         rd(8'hF1);
         chk("status", {fe[0], ov[0], 1'b0, ctl[4:3], r9[0], 1'b0, ok}, rd_val);
         wr(8'hF1, 8'h00);
         i_status_view_select = 1'b0;
         fe = 0;
         $display("test receive case %0d done", i);
      end
      summarize;
   end
endmodule
`default_nettype wire
